// ==== hdl/dcac_channel.sv ====
// Purpose: One DMA channel: start, chaining, abort, drain and burst choice.
// Assumes: Read and write ports answer each request with one ack pulse.
// Notes: Lengths are element counts; the data path itself lives outside.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcac_channel #(
    parameter int BURST = dcac_pkg::BURST_BEATS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic rd_req_o,
    output logic [dcac_pkg::ELEM_W-1:0] rd_len_o,
    input wire logic rd_ack_i,
    input wire logic rd_err_i,
    output logic wr_req_o,
    output logic wr_burst_o,
    output logic wr_eob_o,
    output logic [dcac_pkg::ELEM_W-1:0] wr_len_o,
    input wire logic wr_ack_i,
    input wire logic wr_err_i,
    input wire logic link_in_i,
    output logic link_out_o,
    output logic idle_ack_o,
    output logic irq_o
);
    import dcac_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i+:8] = nw[8*i+:8];
            end
        end
        return r;
    endfunction : merge

    // The chunk comes from the live count and mode only, so an earlier abort cannot leave single beats behind.
    function automatic logic [ELEM_W-1:0] chunk_of(input logic [ELEM_W-1:0] left, input logic burst);
        logic [ELEM_W-1:0] b;
        b = ELEM_W'(BURST);
        if (!burst) begin
            return ELEM_W'(1);
        end
        return (left < b) ? left : b;
    endfunction : chunk_of

    dcac_state_t state_q, state_d;
    logic [31:0] ctrl_q, pcfg_q, mask_q;
    logic [ELEM_W-1:0] ecnt_q, elem_left_q, chunk_q;
    logic [FRAME_W-1:0] frame_left_q;
    logic [1:0] mode_q;
    logic ack_q, stop_q, drain_q, aborted_q, link_q;
    logic [31:0] dat_q;
    logic [EV_W-1:0] sticky;

    // Bus decode.
    wire bus_req = cyc_i & stb_i & ~ack_q;
    wire bus_wr = bus_req & we_i;
    wire bus_rd = bus_req & ~we_i;
    wire wr_ctrl = bus_wr & (adr_i == ADR_CTRL);
    wire [31:0] ctrl_new = merge(ctrl_q, dat_i, sel_i);
    wire [31:0] ecnt_new = merge({8'h00, ecnt_q}, dat_i, sel_i);

    // Channel fields.
    wire en = ctrl_q[CTRL_EN];
    wire pause = ctrl_q[CTRL_PAUSE];
    wire drain_cand = ctrl_q[CTRL_DRAIN];
    wire linked = ctrl_q[CTRL_LINKED];
    wire [FRAME_W-1:0] frames = ctrl_q[FRAME_LSB+:FRAME_W];
    wire [FRAME_W-1:0] frames_new = ctrl_new[FRAME_LSB+:FRAME_W];
    wire sw_sync_new = (ctrl_new[SYNC_LO_LSB+:SYNC_LO_W] == '0) & (ctrl_new[SYNC_HI_LSB+:SYNC_HI_W] == '0);
    wire sw_sync = (ctrl_q[SYNC_LO_LSB+:SYNC_LO_W] == '0) & (ctrl_q[SYNC_HI_LSB+:SYNC_HI_W] == '0);
    wire burst_sel = pcfg_q[PCFG_BURST] & pcfg_q[PCFG_PACK];

    // Starts: a software write of one, or the link into a non-head chain member.
    wire idle = (state_q == ST_IDLE);
    wire sw_start = wr_ctrl & sel_i[0] & ctrl_new[CTRL_EN] & idle;
    wire link_start = link_in_i & linked & idle & ~sw_start;
    wire start_frames0 = sw_start ? (frames_new == '0) : (frames == '0);
    wire start_sw_sync = sw_start ? sw_sync_new : sw_sync;
    wire start = sw_start | link_start;
    wire misalign = start & start_sw_sync & start_frames0;
    wire sw_disable = wr_ctrl & sel_i[0] & ~ctrl_new[CTRL_EN] & ~idle;

    // Transfer progress.
    wire eob = (frame_left_q == FRAME_W'(1)) & (chunk_q == elem_left_q);
    wire rd_done = (state_q == ST_READ) & rd_ack_i;
    wire wr_done = (state_q == ST_WRITE) & wr_ack_i;
    wire rd_abort = rd_done & rd_err_i & ~drain_cand;
    wire rd_drain = rd_done & rd_err_i & drain_cand;
    wire wr_abort = wr_done & wr_err_i & ~eob;
    wire stop_now = (stop_q | sw_disable) & ~drain_cand;
    wire disable_abort = stop_now & ((state_q == ST_READ) & ~rd_done | (state_q == ST_LOAD));
    wire abort = rd_abort | wr_abort | disable_abort;
    wire finish = rd_drain | (wr_done & ~wr_abort & (eob | drain_q | stop_q | sw_disable));
    wire load_go = (state_q == ST_LOAD) & ~pause & ~disable_abort;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start & ~misalign) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (disable_abort) begin
                    state_d = ST_IDLE;
                end else if (load_go) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                if (abort | rd_drain) begin
                    state_d = ST_IDLE;
                end else if (rd_done) begin
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (abort | finish) begin
                    state_d = ST_IDLE;
                end else if (wr_done) begin
                    state_d = ST_READ;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Control register; hardware clears the enable on abort, end and misalignment.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= REG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new;
            end
            if (link_start & ~misalign) begin
                ctrl_q[CTRL_EN] <= 1'b1;
            end
            if (abort | finish | misalign) begin
                ctrl_q[CTRL_EN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcfg_q <= REG_RESET;
            ecnt_q <= '0;
            mask_q <= REG_RESET;
            mode_q <= MODE_NO;
        end else begin
            if (bus_wr & (adr_i == ADR_PCFG)) begin
                pcfg_q <= merge(pcfg_q, dat_i, sel_i);
            end
            if (bus_wr & (adr_i == ADR_ECNT)) begin
                ecnt_q <= ecnt_new[ELEM_W-1:0];
            end
            if (bus_wr & (adr_i == ADR_MASK)) begin
                mask_q <= merge(mask_q, dat_i, sel_i);
            end
            if (bus_wr & (adr_i == ADR_MODE) & sel_i[0]) begin
                mode_q <= dat_i[1:0];
            end
        end
    end

    // Counters and the pending disable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            elem_left_q <= '0;
            frame_left_q <= '0;
            chunk_q <= '0;
            stop_q <= 1'b0;
            drain_q <= 1'b0;
        end else begin
            if (load_go) begin
                elem_left_q <= ecnt_q;
                frame_left_q <= frames;
                chunk_q <= chunk_of(ecnt_q, burst_sel);
            end else if (wr_done & ~wr_abort) begin
                if (chunk_q == elem_left_q) begin
                    elem_left_q <= ecnt_q;
                    frame_left_q <= frame_left_q - FRAME_W'(1);
                    chunk_q <= chunk_of(ecnt_q, burst_sel);
                end else begin
                    elem_left_q <= elem_left_q - chunk_q;
                    chunk_q <= chunk_of(elem_left_q - chunk_q, burst_sel);
                end
            end
            if (idle) begin
                stop_q <= 1'b0;
                drain_q <= 1'b0;
            end else if (sw_disable) begin
                stop_q <= 1'b1;
                drain_q <= drain_cand;
            end
        end
    end

    // Abort history is kept for status only; it never alters the burst choice.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aborted_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            if (abort) begin
                aborted_q <= 1'b1;
            end else if (sw_start) begin
                aborted_q <= 1'b0;
            end
            link_q <= wr_done & ~wr_abort & eob;
        end
    end

    assign rd_req_o = (state_q == ST_READ);
    assign rd_len_o = chunk_q;
    assign wr_req_o = (state_q == ST_WRITE);
    assign wr_burst_o = burst_sel & (chunk_q > ELEM_W'(1));
    assign wr_eob_o = eob;
    assign wr_len_o = chunk_q;
    assign link_out_o = link_q;

    // Status: bit 15 high while a descriptor load waits, bit 7 high while the channel runs.
    wire [31:0] status = {16'h0000, (state_q == ST_LOAD), 7'h00, ~idle, 3'h0, aborted_q, sticky};
    wire [EV_W-1:0] events = {finish, misalign, abort};

    dcac_irq #(
        .W(EV_W)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(events),
        .clear_i(bus_rd & (adr_i == ADR_STAT)),
        .mask_i(mask_q[EV_W-1:0]),
        .sticky_o(sticky),
        .irq_o(irq_o)
    );

    dcac_standby u_stby (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode_q),
        .busy_i(~idle),
        .idle_ack_o(idle_ack_o)
    );

    // Bus answer one cycle after the request; unmapped reads give zero.
    wire [31:0] rd_mux = (adr_i == ADR_CTRL) ? ctrl_q :
                         (adr_i == ADR_PCFG) ? pcfg_q :
                         (adr_i == ADR_ECNT) ? {8'h00, ecnt_q} :
                         (adr_i == ADR_STAT) ? status :
                         (adr_i == ADR_MASK) ? mask_q :
                         (adr_i == ADR_MODE) ? {30'h0, mode_q} : 32'h0000_0000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= bus_req;
            if (bus_rd) begin
                dat_q <= rd_mux;
            end
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    property p_burst;
        @(posedge clk_i) disable iff (rst_i)
            wr_req_o & burst_sel & (elem_left_q >= ELEM_W'(BURST)) |-> wr_burst_o & (wr_len_o == ELEM_W'(BURST));
    endproperty
    a_burst: assert property (p_burst) else $error("Packed burst channel wrote singles.");
    c_burst: cover property (@(posedge clk_i) disable iff (rst_i) wr_req_o & wr_burst_o & aborted_q);
    property p_swsync;
        @(posedge clk_i) disable iff (rst_i)
            sw_start & sw_sync_new & (frames_new == '0) |=> idle & ~en & sticky[EV_MISALIGN];
    endproperty
    a_swsync: assert property (p_swsync) else $error("Zero-frame start gave no misalignment.");
    property p_wr_abort;
        @(posedge clk_i) disable iff (rst_i) wr_done & wr_err_i & ~eob |=> idle & ~en & ~link_out_o;
    endproperty
    a_wr_abort: assert property (p_wr_abort) else $error("Write error did not abort cleanly.");
    property p_wr_eob;
        @(posedge clk_i) disable iff (rst_i)
            wr_done & wr_err_i & eob |=> link_out_o & ~sticky[EV_ABORT] & (aborted_q == $past(aborted_q));
    endproperty
    a_wr_eob: assert property (p_wr_eob) else $error("End-of-block write error aborted.");
    property p_disable;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == ST_READ) & ~rd_ack_i & sw_disable & ~drain_cand |=> idle & aborted_q;
    endproperty
    a_disable: assert property (p_disable) else $error("Disable without drain did not abort.");
    property p_rd_err;
        @(posedge clk_i) disable iff (rst_i)
            rd_done & rd_err_i |=> idle & (aborted_q == ~$past(drain_cand)) | $past(aborted_q);
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("Read error handling wrong.");
    property p_link;
        @(posedge clk_i) disable iff (rst_i) link_start & ~misalign |=> en ##1 ~idle;
    endproperty
    a_link: assert property (p_link) else $error("Link did not enable the channel.");
    property p_no_stray_start;
        @(posedge clk_i) disable iff (rst_i) idle & ~link_in_i & ~sw_start |=> idle;
    endproperty
    a_no_stray_start: assert property (p_no_stray_start) else $error("Channel left idle without a start.");
    property p_start;
        @(posedge clk_i) disable iff (rst_i) sw_start & ~misalign |=> en & (state_q == ST_LOAD);
    endproperty
    a_start: assert property (p_start) else $error("Enable write did not start the channel.");
    property p_status;
        @(posedge clk_i) disable iff (rst_i)
            (abort | finish) |=> (status[STAT_ACTIVE] == 1'b0) & (status[STAT_LOAD] == 1'b0);
    endproperty
    a_status: assert property (p_status) else $error("Status bits not clear after termination.");
    property p_pause;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == ST_LOAD) & ~pause & ~stop_now |=> (state_q == ST_READ) & ~status[STAT_LOAD];
    endproperty
    a_pause: assert property (p_pause) else $error("Pause clear did not resume descriptor load.");
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_o |=> ~ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Bus ack lasted more than one cycle.");
    c_link: cover property (@(posedge clk_i) disable iff (rst_i) link_start ##[1:300] link_out_o);
    c_abort: cover property (@(posedge clk_i) disable iff (rst_i) wr_abort);
    c_smart: cover property (@(posedge clk_i) disable iff (rst_i) (mode_q == MODE_SMART) & (state_q == ST_LOAD) & pause);
endmodule : dcac_channel
`default_nettype wire

// ==== hdl/dcac_irq.sv ====
// Purpose: Sticky event status, mask and level interrupt.
// Assumes: Events are one-cycle pulses.
// Notes: A new event in the clearing read cycle survives the clear.
`timescale 1ns/1ps
`default_nettype none
module dcac_irq #(
    parameter int W = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] event_i,
    input wire logic clear_i,
    input wire logic [W-1:0] mask_i,
    output logic [W-1:0] sticky_o,
    output logic irq_o
);
    logic [W-1:0] sticky_q;
    wire [W-1:0] sticky_d = (clear_i ? '0 : sticky_q) | event_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky_q <= '0;
        end else begin
            sticky_q <= sticky_d;
        end
    end
    assign sticky_o = sticky_q;
    assign irq_o = |(sticky_q & mask_i);
endmodule : dcac_irq
`default_nettype wire

// ==== hdl/dcac_pkg.sv ====
// Purpose: Constants for the DMA channel abort and chain control block.
// Assumes: Classic Wishbone slave, 32-bit data, one clock.
// Notes: Register offsets are byte addresses.
// What this block does
// - Destination burst with packing gives burst writes, even after an earlier abort and a link enable.
// - Both sync-select fields at zero mean software synchronization.
// - A write-port error before the end of the block makes a clean abort that clears the enable.
// - A disable during a descriptor load or an unacked read aborts unless the channel may drain; during a write it ends after that write.
// - A write-port error aborts the channel unless it hits the end-of-block transaction.
// - A read-port error aborts the channel unless it may drain.
// - A chained channel that is not the head is enabled by the link from the channel before it.
// - Writing one into the enable field starts the channel.
// - A software-synchronized start with zero frames raises the misalignment interrupt and leaves the channel idle.
// - Status bit 15 reads zero once the descriptor load is done; bits 15 and 7 both read zero once the channel has ended.
// - No, force and smart standby exist, and clearing pause resumes a pending descriptor load in every mode.
`default_nettype none
package dcac_pkg;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_PCFG = 8'h04;
    localparam logic [7:0] ADR_ECNT = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    localparam logic [7:0] ADR_MASK = 8'h10;
    localparam logic [7:0] ADR_MODE = 8'h14;
    localparam int CTRL_EN = 0;
    localparam int CTRL_PAUSE = 1;
    localparam int CTRL_DRAIN = 2;
    localparam int CTRL_LINKED = 3;
    localparam int SYNC_LO_LSB = 4;
    localparam int SYNC_LO_W = 5;
    localparam int SYNC_HI_LSB = 9;
    localparam int SYNC_HI_W = 2;
    localparam int FRAME_LSB = 16;
    localparam int FRAME_W = 16;
    localparam int PCFG_BURST = 0;
    localparam int PCFG_PACK = 1;
    localparam int PCFG_PREFETCH = 2;
    localparam int ELEM_W = 24;
    localparam int STAT_LOAD = 15;
    localparam int STAT_ACTIVE = 7;
    localparam int EV_ABORT = 0;
    localparam int EV_MISALIGN = 1;
    localparam int EV_DONE = 2;
    localparam int EV_W = 3;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] MODE_NO = 2'h0;
    localparam logic [1:0] MODE_FORCE = 2'h1;
    localparam logic [1:0] MODE_SMART = 2'h2;
    localparam int BURST_BEATS = 4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_READ = 2'b10,
        ST_WRITE = 2'b11
    } dcac_state_t;
endpackage : dcac_pkg
`default_nettype wire

// ==== hdl/dcac_standby.sv ====
// Purpose: Idle acknowledge for the no, force and smart standby modes.
// Assumes: Busy is high while any transfer or descriptor load is open.
// Notes: Force standby acks at once; the channel must not rely on it to resume.
`timescale 1ns/1ps
`default_nettype none
module dcac_standby (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic busy_i,
    output logic idle_ack_o
);
    import dcac_pkg::*;
    logic ack_q;
    wire ack_d = (mode_i == MODE_FORCE) | ((mode_i == MODE_SMART) & ~busy_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end
    assign idle_ack_o = ack_q;
endmodule : dcac_standby
`default_nettype wire

// ==== sim/dcac_channel_tb.sv ====
// Purpose: Self-checking bench for one DMA channel control block.
// Assumes: Mask is all ones outside the masking scenario.
// Notes: Completion is awaited through the interrupt line, never by fixed delays.
`timescale 1ns/1ps
`default_nettype none
module dcac_channel_tb;
    import dcac_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, link_in_i, ack_o, irq_o, idle_ack_o, link_out_o;
    logic [7:0] adr_i, rd_dly, wr_dly;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, s;
    logic rd_req_o, rd_ack_i, rd_err_i, wr_req_o, wr_burst_o, wr_eob_o, wr_ack_i, wr_err_i;
    logic rd_arm, wr_arm, wr_eob_only;
    logic [ELEM_W-1:0] rd_len_o, wr_len_o;
    int mismatches, n_compared, nwr, nburst, nlink, nelem, neob, nrd;
    dcac_channel #(.BURST(4)) dcac_channel_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rd_req_o(rd_req_o), .rd_len_o(rd_len_o), .rd_ack_i(rd_ack_i), .rd_err_i(rd_err_i),
        .wr_req_o(wr_req_o), .wr_burst_o(wr_burst_o), .wr_eob_o(wr_eob_o), .wr_len_o(wr_len_o),
        .wr_ack_i(wr_ack_i), .wr_err_i(wr_err_i), .link_in_i(link_in_i), .link_out_o(link_out_o),
        .idle_ack_o(idle_ack_o), .irq_o(irq_o));
    dcac_port_model dcac_port_model_inst (.clk_i(clk_i), .rst_i(rst_i), .rd_dly_i(rd_dly), .wr_dly_i(wr_dly),
        .rd_err_arm_i(rd_arm), .wr_err_arm_i(wr_arm), .wr_err_eob_i(wr_eob_only), .rd_req_i(rd_req_o),
        .wr_req_i(wr_req_o), .wr_eob_i(wr_eob_o), .rd_ack_o(rd_ack_i), .rd_err_o(rd_err_i),
        .wr_ack_o(wr_ack_i), .wr_err_o(wr_err_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (wr_req_o === 1'b1 && wr_ack_i === 1'b1) begin
            nwr++;
            nelem += wr_len_o;
            if (wr_eob_o === 1'b1) neob++;
            if (wr_burst_o === 1'b1) nburst++;
        end
        if (rd_req_o === 1'b1 && rd_ack_i === 1'b1) nrd += rd_len_o;
        if (link_out_o === 1'b1) nlink++;
    end
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk("bus ack", 32'h1, 32'h0);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic start(input logic [31:0] ctrl, input logic [31:0] pcfg, input logic [31:0] ecnt);
        wr(ADR_PCFG, pcfg);
        wr(ADR_ECNT, ecnt);
        nwr = 0;
        nburst = 0;
        nlink = 0;
        nelem = 0;
        neob = 0;
        nrd = 0;
        wr(ADR_CTRL, ctrl);
    endtask : start
    // Waits for the interrupt, then reads status; the read also clears the sticky bits.
    task automatic wait_evt(input logic [2:0] exp, input logic [2:0] msk);
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        wb(1'b0, ADR_STAT, 32'h0, s);
        chk("stat events", {29'h0, exp & msk}, {29'h0, s[2:0] & msk});
        chk("stat load and active", 32'h0, {30'h0, s[STAT_LOAD], s[STAT_ACTIVE]});
        repeat (2) @(posedge clk_i);
        chk("irq after clear", 32'h0, {31'h0, irq_o});
    endtask : wait_evt
    task automatic t_regs();
        wb(1'b0, ADR_CTRL, 32'h0, s);
        chk("ctrl reset", REG_RESET, s);
        wb(1'b0, ADR_STAT, 32'h0, s);
        chk("stat reset", REG_RESET, s);
        wr(8'h3c, 32'hffff_ffff);
        wb(1'b0, 8'h3c, 32'h0, s);
        chk("unmapped read", 32'h0, s);
        wr(ADR_MASK, 32'h0000_0007);
        wb(1'b0, ADR_MASK, 32'h0, s);
        chk("mask", 32'h0000_0007, s);
    endtask : t_regs
    task automatic t_basic();
        rd_dly <= 8'h0a;
        start(32'h0001_0001, 32'h0, 32'h2);
        wb(1'b0, ADR_STAT, 32'h0, s);
        chk("stat active", 32'h1, {31'h0, s[STAT_ACTIVE]});
        wait_evt(3'b100, 3'b111);
        chk("writes", 32'h2, nwr);
        chk("link out", 32'h1, nlink);
        rd_dly <= 8'h00;
    endtask : t_basic
    task automatic t_misalign();
        wr(ADR_MASK, 32'h0);
        start(32'h0000_0001, 32'h0, 32'h4);
        repeat (5) @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wb(1'b0, ADR_CTRL, 32'h0, s);
        chk("enable after misalign", 32'h0, {31'h0, s[CTRL_EN]});
        wr(ADR_MASK, 32'h0000_0007);
        wait_evt(3'b010, 3'b111);
        start(32'h0001_0001, 32'h0, 32'h1);
        wait_evt(3'b100, 3'b111);
    endtask : t_misalign
    task automatic t_errors();
        wr_arm <= 1'b1;
        start(32'h0001_0001, 32'h0, 32'h2);
        wait_evt(3'b001, 3'b111);
        chk("writes before abort", 32'h1, nwr);
        wb(1'b0, ADR_CTRL, 32'h0, s);
        chk("enable after abort", 32'h0, {31'h0, s[CTRL_EN]});
        wr_eob_only <= 1'b1;
        start(32'h0001_0001, 32'h0, 32'h2);
        wait_evt(3'b100, 3'b111);
        wr_arm <= 1'b0;
        rd_arm <= 1'b1;
        start(32'h0001_0001, 32'h0, 32'h2);
        wait_evt(3'b001, 3'b111);
        start(32'h0001_0005, 32'h0, 32'h2);
        wait_evt(3'b100, 3'b111);
        rd_arm <= 1'b0;
        rd_dly <= 8'h1e;
        start(32'h0001_0001, 32'h0, 32'h2);
        repeat (5) @(posedge clk_i);
        wr(ADR_CTRL, 32'h0001_0000);
        wait_evt(3'b001, 3'b111);
        chk("writes after disable", 32'h0, nwr);
    endtask : t_errors
    // Follows an abort on purpose: the chained restart must still burst.
    task automatic t_link();
        rd_dly <= 8'h14;
        start(32'h0001_0008, 32'h0000_0003, 32'h9);
        repeat (3) @(posedge clk_i);
        chk("no start without link", 32'h0, {31'h0, rd_req_o});
        link_in_i <= 1'b1;
        @(posedge clk_i);
        link_in_i <= 1'b0;
        wb(1'b0, ADR_CTRL, 32'h0, s);
        chk("enable by link", 32'h1, {31'h0, s[CTRL_EN]});
        wait_evt(3'b100, 3'b111);
        chk("chunks", 32'h3, nwr);
        chk("burst chunks", 32'h2, nburst);
        chk("written elements", 32'h9, nelem);
        chk("read elements", 32'h9, nrd);
        chk("end-of-block writes", 32'h1, neob);
        rd_dly <= 8'h00;
    endtask : t_link
    task automatic t_pause();
        for (int m = 0; m < 3; m++) begin
            wr(ADR_MODE, m);
            start(32'h0001_0003, 32'h0, 32'h1);
            repeat (8) @(posedge clk_i);
            wb(1'b0, ADR_STAT, 32'h0, s);
            chk("load pending", 32'h1, {31'h0, s[STAT_LOAD]});
            chk("read held", 32'h0, {31'h0, rd_req_o});
            chk("idle ack", (m == 1) ? 32'h1 : 32'h0, {31'h0, idle_ack_o});
            wr(ADR_CTRL, 32'h0001_0001);
            wait_evt(3'b100, 3'b111);
        end
    endtask : t_pause
    initial begin
        {cyc_i, stb_i, we_i, link_in_i, rd_arm, wr_arm, wr_eob_only} = 7'h00;
        adr_i = 8'h00;
        dat_i = 32'h0;
        sel_i = 4'hf;
        rd_dly = 8'h00;
        wr_dly = 8'h01;
        mismatches = 0;
        n_compared = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_basic();
        t_misalign();
        t_errors();
        t_link();
        t_pause();
        report_and_stop();
    end
    // The whole sequence needs a few hundred cycles; this is a generous margin.
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
endmodule : dcac_channel_tb
`default_nettype wire

// ==== sim/dcac_port_model.sv ====
// Purpose: Far-side read and write port targets for one DMA channel.
// Assumes: Requests are levels held until the ack pulse.
// Notes: Error replies are armed by the bench; ack delay is programmable.
`timescale 1ns/1ps
`default_nettype none
module dcac_port_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] rd_dly_i,
    input wire logic [7:0] wr_dly_i,
    input wire logic rd_err_arm_i,
    input wire logic wr_err_arm_i,
    input wire logic wr_err_eob_i,
    input wire logic rd_req_i,
    input wire logic wr_req_i,
    input wire logic wr_eob_i,
    output logic rd_ack_o,
    output logic rd_err_o,
    output logic wr_ack_o,
    output logic wr_err_o
);
    logic [7:0] rd_cnt_q;
    logic [7:0] wr_cnt_q;
    wire rd_fire = !rst_i && rd_req_i && !rd_ack_o && rd_cnt_q == rd_dly_i;
    wire wr_fire = !rst_i && wr_req_i && !wr_ack_o && wr_cnt_q == wr_dly_i;
    wire wr_bad = wr_err_arm_i && (!wr_err_eob_i || wr_eob_i);
    // The cycle after an ack is never answered, so a request level that is still high is not acked twice.
    always_ff @(posedge clk_i) begin
        if (rst_i || rd_ack_o || !rd_req_i) begin
            rd_cnt_q <= 8'h00;
        end else if (!rd_fire) begin
            rd_cnt_q <= rd_cnt_q + 8'h01;
        end
        if (rst_i || wr_ack_o || !wr_req_i) begin
            wr_cnt_q <= 8'h00;
        end else if (!wr_fire) begin
            wr_cnt_q <= wr_cnt_q + 8'h01;
        end
        rd_ack_o <= rd_fire;
        wr_ack_o <= wr_fire;
        // Outside an ack the error lines toggle, so nothing can lean on a stale level.
        rd_err_o <= rst_i ? 1'b0 : (rd_fire ? rd_err_arm_i : ~rd_err_o);
        wr_err_o <= rst_i ? 1'b0 : (wr_fire ? wr_bad : ~wr_err_o);
    end
endmodule : dcac_port_model
`default_nettype wire
